// file: rtl/adjsr_ahb_slave.sv
// Purpose: AHB-Lite slave front end, zero wait states
// Assumes: single word transfers, OKAY response always
// Notes: write data applied in the data phase; read data registered at the address phase
`timescale 1ns/1ps
module adjsr_ahb_slave (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // ahb-lite
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic hreadyout_o,
    output logic hresp_o,
    // register side
    output logic wr_en_o,
    output logic [7:0] wr_idx_o,
    output logic [7:0] wr_data_o,
    output logic rd_en_o,
    output logic [7:0] rd_idx_o
);
    logic ph_write;
    logic ph_read;
    logic [7:0] ph_idx;
    wire take = hsel_i && hready_i && htrans_i[1];

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ph_write <= 1'b0;
            ph_read <= 1'b0;
            ph_idx <= 8'h00;
        end else if (hready_i) begin
            ph_write <= take && hwrite_i;
            ph_read <= take && !hwrite_i;
            ph_idx <= haddr_i[9:2];
        end
    end

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign wr_en_o = ph_write;
    assign wr_idx_o = ph_idx;
    assign wr_data_o = hwdata_i[7:0];
    // read data is captured at the address phase so it stands in the data phase
    assign rd_en_o = take && !hwrite_i;
    assign rd_idx_o = haddr_i[9:2];
    logic unused_ok;
    assign unused_ok = ph_read | (|hsize_i) | (|haddr_i[1:0]) | (|haddr_i[31:10]);
endmodule

// file: rtl/adjsr_defs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes: printed offsets are not all multiples of four, so byte address = 4 * index
`ifndef ADJSR_DEFS_SVH
`define ADJSR_DEFS_SVH

// register indices
`define ADJSR_IDX_JACK_STATUS 8'h1C
`define ADJSR_IDX_ACT_CFG 8'h1E
`define ADJSR_IDX_TONE_CFG 8'h1F
`define ADJSR_IDX_CLK_CFG 8'h20
`define ADJSR_IDX_IRQ_STATUS 8'h30
`define ADJSR_IDX_IRQ_MASK 8'h31
`define ADJSR_IDX_POWER_CTRL 8'h32

// reset values
`define ADJSR_RST_JACK_STATUS 8'h00
`define ADJSR_RST_ACT_CFG 8'h20
`define ADJSR_RST_TONE_CFG 8'h80
`define ADJSR_RST_CLK_CFG 8'h00
`define ADJSR_RST_IRQ 8'h00

// writable bits of each register
`define ADJSR_WMASK_ACT_CFG 8'hFB
`define ADJSR_WMASK_TONE_CFG 8'hE0
`define ADJSR_WMASK_CLK_CFG 8'hFC

// field positions
`define ADJSR_JACK_STATE_LSB 6
`define ADJSR_HEADSET_KIND_LSB 4
`define ADJSR_POLICY_LSB 6
`define ADJSR_WATCH_CH_LSB 4
`define ADJSR_IRQ_SERIAL_DATA_OUT_PIN_BIT 3
`define ADJSR_REC_DETECT_BIT 1
`define ADJSR_TONE_CH_LSB 6
`define ADJSR_CLK_SRC_LSB 6
`define ADJSR_EXT_RATE_LSB 4
`define ADJSR_PHASE1_BIT 2

// interrupt status bits
`define ADJSR_EV_ACTIVITY 0
`define ADJSR_EV_JACK_CHANGE 1
`define ADJSR_EV_BAD_POLICY 2
`define ADJSR_NUM_EVENTS 3

// external clock rates in kHz
`define ADJSR_EXT_KHZ_0 32'd24576
`define ADJSR_EXT_KHZ_1 32'd6144
`define ADJSR_EXT_KHZ_2 32'd12288
`define ADJSR_EXT_KHZ_3 32'd18432

// timing: settle time of jack report before it is published
`define ADJSR_CLK_MHZ 40
`define ADJSR_JACK_SETTLE_NS 100
`define ADJSR_JACK_SETTLE_CYC ((`ADJSR_JACK_SETTLE_NS * `ADJSR_CLK_MHZ + 999) / 1000)

`endif

// file: rtl/adjsr_event_block.sv
// Purpose: sticky interrupt status with mask and one level output
// Assumes: write-one-to-clear
// Notes: a set in the cycle of a clear wins
`timescale 1ns/1ps
module adjsr_event_block #(
    parameter int N = 3
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // events and software access
    input wire logic [N-1:0] event_i,
    input wire logic clear_en_i,
    input wire logic [N-1:0] clear_bits_i,
    input wire logic mask_en_i,
    input wire logic [N-1:0] mask_bits_i,
    // state
    output logic [N-1:0] status_o,
    output logic [N-1:0] mask_o,
    output logic irq_o
);
    logic [N-1:0] status;
    logic [N-1:0] mask;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            always_ff @(posedge core_clk_i) begin
                if (reset_i) begin
                    status[g] <= 1'b0;
                end else if (event_i[g]) begin
                    status[g] <= 1'b1;
                end else if (clear_en_i && clear_bits_i[g]) begin
                    status[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            mask <= '0;
        end else if (mask_en_i) begin
            mask <= mask_bits_i;
        end
    end

    assign status_o = status;
    assign mask_o = mask;
    assign irq_o = |(status & mask);
endmodule

// file: rtl/adjsr_pkg.sv
// Purpose: shared types for the activity detect, jack status and clock configuration registers
// Assumes: nothing
// Notes: none
package adjsr_pkg;
    typedef enum logic [1:0] {
        ADJSR_JACK_NONE = 2'h0,
        ADJSR_JACK_NO_MIC = 2'h1,
        ADJSR_JACK_RSVD = 2'h2,
        ADJSR_JACK_WITH_MIC = 2'h3
    } adjsr_jack_t;

    typedef enum logic [1:0] {
        ADJSR_POL_SOFTWARE = 2'h0,
        ADJSR_POL_IRQ_UP_DOWN = 2'h1,
        ADJSR_POL_IRQ_UP_SW_DOWN = 2'h2,
        ADJSR_POL_FORBIDDEN = 2'h3
    } adjsr_policy_t;

    typedef enum logic [1:0] {
        ADJSR_CLK_INTERNAL = 2'h0,
        ADJSR_CLK_BIT_CLOCK = 2'h1,
        ADJSR_CLK_CONTROL_CLOCK = 2'h2,
        ADJSR_CLK_CUSTOM = 2'h3
    } adjsr_clk_src_t;

    typedef enum {
        ADJSR_ADC_OFF,
        ADJSR_ADC_ON
    } adjsr_adc_state_t;
endpackage

// file: rtl/adjsr_regs.sv
// Purpose: jack status and low-power activity detect / tone configuration registers
// Assumes: jack detector and activity detector are outside; their results arrive as inputs
// Notes: registers sit at byte address 4 * index on AHB-Lite
// Notes on behaviour
// - jack state reads 0 none, 1 no mic, 2 reserved, 3 with mic
// - headset kind reads 0 none, 1 mono right, 2 mono left, 3 stereo
// - adc power policy: software, irq up/down, irq up sw down; 3 unused
// - watched channel select n means channel n+1; reset selects third channel
// - routing bit set puts activity irq on serial out when not recording
// - detect-during-record bit keeps detection running while recording
// - tone output channel select n means channel n+1; reset selects third
// - clock source: internal, bit clock, control clock, custom configuration
// - external clock rate code: 24.576, 6.144, 12.288, 18.432 MHz
// - first phase detect enable turns on jack comparator detection phase
`timescale 1ns/1ps
`include "adjsr_defs.svh"
module adjsr_regs (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // ahb-lite
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // jack detector results
    input wire logic [1:0] jack_state_i,
    input wire logic [1:0] headset_kind_i,
    input wire logic jack_valid_i,
    // activity detector and recording path
    input wire logic activity_i,
    input wire logic recording_i,
    input wire logic adc_sw_power_up_i,
    input wire logic adc_sw_power_down_i,
    input wire logic serial_data_i,
    // configuration out
    output logic [1:0] watched_channel_select_o,
    output logic [1:0] tone_output_channel_select_o,
    output logic [1:0] low_power_clock_source_o,
    output logic [1:0] external_clock_rate_select_o,
    output logic [31:0] external_clock_khz_o,
    output logic first_phase_detect_enable_o,
    output logic detect_enable_o,
    output logic adc_power_o,
    // serial data out pin and interrupt
    output logic serial_data_out_pin_o,
    output logic irq_o
);
    logic wr_en;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic rd_en;
    logic [7:0] rd_idx;
    logic [7:0] jack_status;
    logic [7:0] act_cfg;
    logic [7:0] tone_cfg;
    logic [7:0] clk_cfg;
    logic [7:0] next_rdata;
    logic [`ADJSR_NUM_EVENTS-1:0] ev_status;
    logic [`ADJSR_NUM_EVENTS-1:0] ev_mask;
    logic [`ADJSR_NUM_EVENTS-1:0] events;
    logic [7:0] settle_cnt;
    logic [3:0] pending_jack;
    logic activity_q;
    logic serial_out;
    adjsr_pkg::adjsr_adc_state_t adc_state;
    adjsr_pkg::adjsr_adc_state_t next_adc_state;

    function automatic logic hit(input logic en, input logic [7:0] idx, input logic [7:0] want);
        hit = en && (idx == want);
    endfunction

    function automatic logic [31:0] rate_khz(input logic [1:0] code);
        case (code)
            2'h0: rate_khz = `ADJSR_EXT_KHZ_0;
            2'h1: rate_khz = `ADJSR_EXT_KHZ_1;
            2'h2: rate_khz = `ADJSR_EXT_KHZ_2;
            default: rate_khz = `ADJSR_EXT_KHZ_3;
        endcase
    endfunction

    adjsr_ahb_slave u_bus (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hready_i(hready_i),
        .hwdata_i(hwdata_i),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .wr_en_o(wr_en),
        .wr_idx_o(wr_idx),
        .wr_data_o(wr_data),
        .rd_en_o(rd_en),
        .rd_idx_o(rd_idx)
    );

    // field views
    wire [1:0] policy = act_cfg[`ADJSR_POLICY_LSB +: 2];
    wire irq_route = act_cfg[`ADJSR_IRQ_SERIAL_DATA_OUT_PIN_BIT];
    wire rec_detect = act_cfg[`ADJSR_REC_DETECT_BIT];
    wire wr_act = hit(wr_en, wr_idx, `ADJSR_IDX_ACT_CFG);
    wire wr_tone = hit(wr_en, wr_idx, `ADJSR_IDX_TONE_CFG);
    wire wr_clk = hit(wr_en, wr_idx, `ADJSR_IDX_CLK_CFG);
    wire wr_irq_clr = hit(wr_en, wr_idx, `ADJSR_IDX_IRQ_STATUS);
    wire wr_irq_mask = hit(wr_en, wr_idx, `ADJSR_IDX_IRQ_MASK);
    wire [7:0] new_jack = (jack_state_i == adjsr_pkg::ADJSR_JACK_NONE) ? 8'h00 :
        {jack_state_i, headset_kind_i, 4'h0};

    // write merge: reserved bits keep their reset values
    wire [7:0] next_act_cfg = (wr_data & `ADJSR_WMASK_ACT_CFG) |
        (`ADJSR_RST_ACT_CFG & ~`ADJSR_WMASK_ACT_CFG);
    wire [7:0] next_tone_cfg = (wr_data & `ADJSR_WMASK_TONE_CFG) |
        (`ADJSR_RST_TONE_CFG & ~`ADJSR_WMASK_TONE_CFG);
    wire [7:0] next_clk_cfg = (wr_data & `ADJSR_WMASK_CLK_CFG) |
        (`ADJSR_RST_CLK_CFG & ~`ADJSR_WMASK_CLK_CFG);

    // activity detect configuration
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            act_cfg <= `ADJSR_RST_ACT_CFG;
        end else if (wr_act) begin
            act_cfg <= next_act_cfg;
        end
    end

    // tone generation configuration
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            tone_cfg <= `ADJSR_RST_TONE_CFG;
        end else if (wr_tone) begin
            tone_cfg <= next_tone_cfg;
        end
    end

    // low-power clock configuration
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            clk_cfg <= `ADJSR_RST_CLK_CFG;
        end else if (wr_clk) begin
            clk_cfg <= next_clk_cfg;
        end
    end

    // jack report: both fields captured in one write after a short settle
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            jack_status <= `ADJSR_RST_JACK_STATUS;
            pending_jack <= 4'h0;
            settle_cnt <= 8'h00;
        end else if (jack_valid_i && (new_jack[7:4] != pending_jack)) begin
            pending_jack <= new_jack[7:4];
            settle_cnt <= 8'(`ADJSR_JACK_SETTLE_CYC);
        end else if (settle_cnt > 8'h01) begin
            settle_cnt <= settle_cnt - 8'h01;
        end else if (settle_cnt == 8'h01) begin
            settle_cnt <= 8'h00;
            jack_status <= {pending_jack, 4'h0};
        end
    end

    // detection gating during recording
    assign detect_enable_o = !recording_i || rec_detect;
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            activity_q <= 1'b0;
        end else begin
            activity_q <= activity_i && detect_enable_o;
        end
    end

    // adc auto power sequencing
    always_comb begin
        next_adc_state = adc_state;
        case (policy)
            adjsr_pkg::ADJSR_POL_SOFTWARE: begin
                if (adc_sw_power_up_i) begin
                    next_adc_state = adjsr_pkg::ADJSR_ADC_ON;
                end else if (adc_sw_power_down_i) begin
                    next_adc_state = adjsr_pkg::ADJSR_ADC_OFF;
                end
            end
            adjsr_pkg::ADJSR_POL_IRQ_UP_DOWN: begin
                next_adc_state = activity_q ? adjsr_pkg::ADJSR_ADC_ON :
                    adjsr_pkg::ADJSR_ADC_OFF;
            end
            adjsr_pkg::ADJSR_POL_IRQ_UP_SW_DOWN: begin
                if (activity_q) begin
                    next_adc_state = adjsr_pkg::ADJSR_ADC_ON;
                end else if (adc_sw_power_down_i) begin
                    next_adc_state = adjsr_pkg::ADJSR_ADC_OFF;
                end
            end
            default: begin
                next_adc_state = adc_state;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            adc_state <= adjsr_pkg::ADJSR_ADC_OFF;
        end else begin
            adc_state <= next_adc_state;
        end
    end
    assign adc_power_o = (adc_state == adjsr_pkg::ADJSR_ADC_ON);

    // events: activity, jack change, forbidden policy value
    assign events[`ADJSR_EV_ACTIVITY] = activity_i && detect_enable_o && !activity_q;
    assign events[`ADJSR_EV_JACK_CHANGE] = (settle_cnt == 8'h01) &&
        ({pending_jack, 4'h0} != jack_status);
    assign events[`ADJSR_EV_BAD_POLICY] = (policy == adjsr_pkg::ADJSR_POL_FORBIDDEN);

    adjsr_event_block #(
        .N(`ADJSR_NUM_EVENTS)
    ) u_events (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .event_i(events),
        .clear_en_i(wr_irq_clr),
        .clear_bits_i(wr_data[`ADJSR_NUM_EVENTS-1:0]),
        .mask_en_i(wr_irq_mask),
        .mask_bits_i(wr_data[`ADJSR_NUM_EVENTS-1:0]),
        .status_o(ev_status),
        .mask_o(ev_mask),
        .irq_o(irq_o)
    );

    // serial data out pin: activity interrupt status only when routed and not recording
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            serial_out <= 1'b0;
        end else if (irq_route && !recording_i) begin
            serial_out <= ev_status[`ADJSR_EV_ACTIVITY];
        end else begin
            serial_out <= serial_data_i;
        end
    end
    assign serial_data_out_pin_o = serial_out;

    // configuration outputs
    assign watched_channel_select_o = act_cfg[`ADJSR_WATCH_CH_LSB +: 2];
    assign tone_output_channel_select_o = tone_cfg[`ADJSR_TONE_CH_LSB +: 2];
    assign low_power_clock_source_o = clk_cfg[`ADJSR_CLK_SRC_LSB +: 2];
    assign external_clock_rate_select_o = clk_cfg[`ADJSR_EXT_RATE_LSB +: 2];
    assign first_phase_detect_enable_o = clk_cfg[`ADJSR_PHASE1_BIT];
    assign external_clock_khz_o = rate_khz(external_clock_rate_select_o);

    // read selects
    wire rd_jack = hit(1'b1, rd_idx, `ADJSR_IDX_JACK_STATUS);
    wire rd_act = hit(1'b1, rd_idx, `ADJSR_IDX_ACT_CFG);
    wire rd_tone = hit(1'b1, rd_idx, `ADJSR_IDX_TONE_CFG);
    wire rd_clk = hit(1'b1, rd_idx, `ADJSR_IDX_CLK_CFG);
    wire rd_sts = hit(1'b1, rd_idx, `ADJSR_IDX_IRQ_STATUS);
    wire rd_msk = hit(1'b1, rd_idx, `ADJSR_IDX_IRQ_MASK);
    wire rd_pwr = hit(1'b1, rd_idx, `ADJSR_IDX_POWER_CTRL);

    // read mux, unmapped reads return zero
    assign next_rdata =
        rd_jack ? jack_status :
        rd_act ? act_cfg :
        rd_tone ? tone_cfg :
        rd_clk ? clk_cfg :
        rd_sts ? {5'h00, ev_status} :
        rd_msk ? {5'h00, ev_mask} :
        rd_pwr ? {7'h00, adc_power_o} :
        8'h00;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (rd_en) begin
            hrdata_o <= {24'h000000, next_rdata};
        end
    end
endmodule

// file: testbench/adjsr_regs_properties.sv
// Purpose: timing properties of the register block at its ports
// Assumes: zero-wait bus, config outputs straight from registers
// Notes: byte address = 4 * index
`timescale 1ns/1ps
module adjsr_regs_properties (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    input wire logic [31:0] hrdata_o,
    // pins
    input wire logic recording_i,
    input wire logic serial_data_i,
    input wire logic [1:0] watched_channel_select_o,
    input wire logic [1:0] tone_output_channel_select_o,
    input wire logic [1:0] low_power_clock_source_o,
    input wire logic [1:0] external_clock_rate_select_o,
    input wire logic [31:0] external_clock_khz_o,
    input wire logic detect_enable_o,
    input wire logic serial_data_out_pin_o,
    input wire logic irq_o
);
    wire take = hsel_i && hready_i && htrans_i[1];
    wire wr_act = take && hwrite_i && haddr_i == 32'h78;
    wire wr_tone = take && hwrite_i && haddr_i == 32'h7C;
    wire wr_clk = take && hwrite_i && haddr_i == 32'h80;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    a_watch_from_write: assert property ($changed(watched_channel_select_o) |->
        $past(wr_act, 2) && watched_channel_select_o == $past(hwdata_i[5:4]))
        else $error("watched channel moved without write");
    a_tone_from_write: assert property ($changed(tone_output_channel_select_o) |->
        $past(wr_tone, 2) && tone_output_channel_select_o == $past(hwdata_i[7:6]))
        else $error("tone channel moved without write");
    a_clock_src_write: assert property ($changed(low_power_clock_source_o) |->
        $past(wr_clk, 2) && low_power_clock_source_o == $past(hwdata_i[7:6]))
        else $error("clock source moved without write");
    a_rate_decode: assert property (external_clock_khz_o ==
        (external_clock_rate_select_o == 2'h0 ? 32'h6000 : external_clock_rate_select_o == 2'h1 ?
        32'h1800 : external_clock_rate_select_o == 2'h2 ? 32'h3000 : 32'h4800))
        else $error("clock rate decode wrong");
    a_detect_idle: assert property (!recording_i |-> detect_enable_o)
        else $error("detection off while idle");
    a_pin_recording: assert property ($past(recording_i) && !$past(reset_i) |->
        serial_data_out_pin_o == $past(serial_data_i))
        else $error("pin not serial data while recording");
    a_irq_fall_write: assert property ($fell(irq_o) |->
        $past(take && hwrite_i && haddr_i[31:3] == 29'h18, 2))
        else $error("interrupt fell without write");
    a_jack_read_shape: assert property (take && !hwrite_i && haddr_i == 32'h70 |=>
        hrdata_o[3:0] == 4'h0 && (hrdata_o[7:6] != 2'h0 || hrdata_o[5:4] == 2'h0))
        else $error("jack status read malformed");
endmodule

bind adjsr_regs adjsr_regs_properties u_adjsr_regs_properties (.*);

// file: testbench/adjsr_regs_tb_top.sv
// Purpose: self-checking bench for the register block
// Assumes: zero-wait bus, jack report settles in 4 cycles
// Notes: reads queue their expected value; a monitor compares in the data phase
`timescale 1ns/1ps
module adjsr_regs_tb_top;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0;
    logic [1:0] jack_state_i = 2'h0;
    logic [1:0] headset_kind_i = 2'h0;
    logic jack_valid_i = 1'b0;
    logic activity_i = 1'b0;
    logic recording_i = 1'b0;
    logic adc_sw_power_up_i = 1'b0;
    logic adc_sw_power_down_i = 1'b0;
    logic serial_data_i = 1'b0;
    logic [31:0] hrdata_o, external_clock_khz_o;
    logic [1:0] watched_channel_select_o, tone_output_channel_select_o;
    logic [1:0] low_power_clock_source_o, external_clock_rate_select_o;
    logic hreadyout_o, hresp_o, first_phase_detect_enable_o, detect_enable_o;
    logic adc_power_o, serial_data_out_pin_o, irq_o;
    wire hready_i = hreadyout_o;
    int n_errors = 0;
    int compares = 0;
    logic [31:0] exp_q [$];
    logic rd_ph = 1'b0;
    // byte address = 4 * index
    localparam logic [31:0] ad_jack = 32'h70;
    localparam logic [31:0] ad_act = 32'h78;
    localparam logic [31:0] ad_tone = 32'h7C;
    localparam logic [31:0] ad_clk = 32'h80;
    localparam logic [31:0] ad_sts = 32'hC0;
    localparam logic [31:0] ad_msk = 32'hC4;
    localparam logic [31:0] ad_pwr = 32'hC8;

    adjsr_regs u_adjsr_regs (.*);

    always #12.5 core_clk_i = ~core_clk_i;

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // read data lands one edge after its address phase
    always @(posedge core_clk_i) begin
        if (rd_ph) chk("hrdata", hrdata_o, exp_q.pop_front());
        rd_ph <= !reset_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    end

    task cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge core_clk_i); while (hready_i !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        if (w) hwdata_i <= d;
        do @(posedge core_clk_i); while (hready_i !== 1'b1);
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask

    task sw(input logic up);
        adc_sw_power_up_i <= up;
        adc_sw_power_down_i <= !up;
        cyc(1);
        adc_sw_power_up_i <= 1'b0;
        adc_sw_power_down_i <= 1'b0;
        cyc(3);
    endtask

    task act(input int hi, input int lo);
        activity_i <= 1'b1;
        cyc(hi);
        activity_i <= 1'b0;
        cyc(lo);
    endtask

    task summarize;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        cyc(5000);
        n_errors++;
        $display("FAIL watchdog expected end seen hang");
        summarize();
    end

    initial begin
        logic [31:0] r, jx;
        logic [7:0] v;
        logic [1:0] js;
        logic [31:0] ktab [4];
        int i;
        ktab = '{32'h6000, 32'h1800, 32'h3000, 32'h4800};
        r = $urandom(54795);
        jx = 32'h0;
        cyc(3);
        reset_i <= 1'b0;
        cyc(1);
        rd(ad_jack, 32'h0);
        rd(ad_act, 32'h20);
        rd(ad_tone, 32'h80);
        rd(ad_clk, 32'h0);
        rd(32'h100, 32'h0);
        chk("watch", watched_channel_select_o, 32'h2);
        chk("tone", tone_output_channel_select_o, 32'h2);
        chk("hresp", hresp_o, 32'h0);
        chk("hready", hreadyout_o, 32'h1);
        $display("test reset values done");
        for (i = 0; i < 4; i++) begin
            r = $urandom;
            v = {2'h0, 2'(i), r[0], 1'b0, r[1], 1'b0};
            wr(ad_act, {24'h0, v});
            rd(ad_act, {24'h0, v});
            wr(ad_tone, {24'h0, 2'(i), 6'h0});
            rd(ad_tone, {24'h0, 2'(i), 6'h0});
            v = {2'(i), 2'(3 - i), 1'b0, r[2], 2'h0};
            wr(ad_clk, {24'h0, v});
            rd(ad_clk, {24'h0, v});
            chk("watch", watched_channel_select_o, i);
            chk("tone", tone_output_channel_select_o, i);
            chk("clksrc", low_power_clock_source_o, i);
            chk("khz", external_clock_khz_o, ktab[3 - i]);
            chk("phase1", first_phase_detect_enable_o, r[2]);
            chk("rate", external_clock_rate_select_o, 3 - i);
        end
        $display("test config fields done");
        wr(ad_msk, 32'h7);
        for (i = 0; i < 3; i++) begin
            r = $urandom;
            js = (i == 2) ? 2'h0 : 2'(2 * i + 1);
            jack_state_i <= js;
            headset_kind_i <= r[1:0];
            jack_valid_i <= 1'b1;
            rd(ad_jack, jx);
            jx = (js == 2'h0) ? 32'h0 : {24'h0, js, r[1:0], 4'h0};
            cyc(6);
            rd(ad_jack, jx);
        end
        $display("test jack report done");
        rd(ad_sts, 32'h2);
        chk("irq", irq_o, 32'h1);
        wr(ad_sts, 32'h2);
        rd(ad_sts, 32'h0);
        chk("irq", irq_o, 32'h0);
        wr(ad_act, 32'h08);
        act(3, 2);
        chk("irq", irq_o, 32'h1);
        chk("pin", serial_data_out_pin_o, 32'h1);
        chk("detect", detect_enable_o, 32'h1);
        recording_i <= 1'b1;
        serial_data_i <= r[3];
        cyc(2);
        chk("pin", serial_data_out_pin_o, r[3]);
        chk("detect", detect_enable_o, 32'h0);
        wr(ad_act, 32'h0A);
        cyc(1);
        chk("detect", detect_enable_o, 32'h1);
        recording_i <= 1'b0;
        serial_data_i <= 1'b1;
        wr(ad_act, 32'h00);
        wr(ad_sts, 32'h7);
        wr(ad_msk, 32'h0);
        chk("pin", serial_data_out_pin_o, 32'h1);
        act(3, 2);
        chk("irq", irq_o, 32'h0);
        rd(ad_sts, 32'h1);
        $display("test interrupts done");
        sw(1'b1);
        rd(ad_pwr, 32'h1);
        sw(1'b0);
        chk("adc", adc_power_o, 32'h0);
        wr(ad_act, 32'h40);
        act(4, 0);
        chk("adc", adc_power_o, 32'h1);
        cyc(4);
        chk("adc", adc_power_o, 32'h0);
        wr(ad_act, 32'h80);
        act(4, 4);
        chk("adc", adc_power_o, 32'h1);
        sw(1'b0);
        chk("adc", adc_power_o, 32'h0);
        wr(ad_sts, 32'h7);
        wr(ad_act, 32'hC0);
        cyc(1);
        rd(ad_sts, 32'h4);
        $display("test adc policy done");
        cyc(2);
        summarize();
    end
endmodule
